// File: asfp_pkg.sv
// shared constants and types for the converter serial frame and power control block
package asfp_pkg;
   // frame geometry
   localparam int unsigned frame_edges = 16;
   localparam int unsigned result_bits = 12;
   localparam int unsigned lead_zeros = 4;
   localparam logic [4:0] last_shift_edge = 5'h0f;
   localparam logic [4:0] track_after_edge = 5'h0d;
   localparam logic [4:0] end_edge = 5'h10;
   localparam logic [4:0] keep_power_edge = 5'h0a;
   localparam logic [4:0] glitch_edge = 5'h02;
   // timing
   localparam int unsigned clk_period_ns = 8;
   localparam int unsigned powerup_time_ns = 1000;
   localparam int unsigned powerup_cycles = (powerup_time_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int unsigned release_delay_ns = 35;
   localparam int unsigned release_delay_cycles =
      (release_delay_ns / clk_period_ns) < 1 ? 1 : release_delay_ns / clk_period_ns;
   localparam int unsigned acquisition_time_ns = 290;
   localparam int unsigned quiet_time_ns = 60;
   // power modes
   typedef enum logic [1:0] {
      asfp_pw_normal,
      asfp_pw_down,
      asfp_pw_waking
   } asfp_power_t;
endpackage

// File: asfp_frame_if.sv
// interface carrying the frame events from the top module to the shift register
interface asfp_frame_if;
   logic start;
   logic shift;
   logic stop;
   logic [11:0] sample;
   logic bit_out;
   modport ctrl (output start, output shift, output stop, output sample, input bit_out);
   modport shifter (input start, input shift, input stop, input sample, output bit_out);
endinterface

// File: asfp_shifter.sv
// result shift register: four leading zeros then the two's complement result, msb first
module asfp_shifter (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // frame events
   asfp_frame_if.shifter fr
);
   logic [15:0] word_q;
   logic [15:0] word_d;

   // load on select fall so the first zero shows at once; shift on each falling edge but the sixteenth
   assign word_d = fr.start ? {4'h0, fr.sample} :
                   fr.shift ? {word_q[14:0], 1'b0} : word_q; // see R6, R8
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         word_q <= 16'h0000;
      end else begin
         word_q <= word_d;
      end
   end

   assign fr.bit_out = word_q[15];
endmodule

// File: asfp_ctrl.sv
// top of the converter serial frame and power-mode control block
//
// Overview of operation
// R1: the serial clock paces both the conversion and the data shift; sixteen clocks.
// R2: select falling freezes the sample, starts conversion, drives the data pin.
// R3: after the thirteenth falling edge, tracking resumes on the next rising edge.
// R4: data pin floats on the sixteenth falling edge of a complete frame.
// R5: select rising before sixteen clocks aborts conversion and floats data.
// R6: each bit shifts on a falling edge; four zeros then twelve bits, msb first.
// R7: the result is two's complement.
// R8: first zero at select fall, second zero at the first falling edge.
// R9: last bit leaves on edge fifteen; the host takes it on edge sixteen.
// R10: a slow host may sample on rising edges instead.
// R11: host leaves at least 290 ns acquisition between frames.
// R12: host waits the 60 ns quiet time after float before a new frame.
// R13: host holds select low past ten falling edges to stay powered.
// R14: rise between edges ten and sixteen keeps power, aborts, floats data.
// R15: host may idle select high or low between normal conversions.
// R16: rise after edge two but before ten powers down and aborts.
// R17: rise before edge two keeps normal mode, ignoring glitches.
// R18: an abort floats the data pin within 35 ns of select rising.
// R19: from power-down, wake starts at select fall, completes past edge ten.
// R20: a wake frame ended before edge ten returns to power-down.
// R21: after a dummy frame power is full within 1 us; dummy data invalid.
// R22: host may rely on one dummy frame at up to 10 MHz, then quiet time.
// R23: the mode after supply is undetermined; a dummy frame sets it.
// R24: on wake, tracking resumes at the first serial clock edge after select fall.
// R25: the falling-edge count restarts each frame; its value at select rise decides.
module asfp_ctrl (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // serial link pins from the host
   input wire logic frame_sel_n,
   input wire logic serial_clk,
   // serial data pin
   output logic result_out,
   output logic result_out_oe,
   // converter core
   input wire logic [11:0] core_result,
   output logic sampler_hold,
   output logic analog_on,
   output logic power_good,
   output logic data_valid
);
   // synchroniser stages
   logic sel_s1_q;
   logic sel_s2_q;
   logic sel_s3_q;
   logic sclk_s1_q;
   logic sclk_s2_q;
   logic sclk_s3_q;
   // frame state
   logic in_frame_q;
   logic [4:0] edge_cnt_q;
   logic oe_q;
   logic hold_q;
   logic track_pend_q;
   logic wake_track_q;
   logic dummy_q;
   logic valid_q;
   asfp_pkg::asfp_power_t pw_q;
   asfp_pkg::asfp_power_t pw_d;
   logic [7:0] pu_cnt_q;
   logic strap_done_q;

   asfp_frame_if fr ();

   // pins come from the host's domain, so two flops before any logic looks at them
   always_ff @(posedge sys_clk) begin
      sel_s1_q <= frame_sel_n;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
      sclk_s1_q <= serial_clk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
   end

   // edge detection on the synchronised copies only
   wire sel_fall = sel_s3_q & ~sel_s2_q;
   wire sel_rise = ~sel_s3_q & sel_s2_q;
   wire sclk_fall = sclk_s3_q & ~sclk_s2_q;
   wire sclk_rise = ~sclk_s3_q & sclk_s2_q;
   wire frame_fall = in_frame_q & sclk_fall & (edge_cnt_q != asfp_pkg::end_edge);
   wire last_fall = frame_fall & (edge_cnt_q == asfp_pkg::last_shift_edge);
   wire early_rise = in_frame_q & sel_rise;
   // a rise after a complete frame is not an abort and must keep the valid flag
   wire abort_rise = early_rise & (edge_cnt_q != asfp_pkg::end_edge);
   wire below_two = edge_cnt_q < asfp_pkg::glitch_edge;
   wire below_ten = edge_cnt_q < asfp_pkg::keep_power_edge;
   wire pw_down = pw_q == asfp_pkg::asfp_pw_down;

   // frame events to the shift register
   assign fr.start = sel_fall; // see R2
   assign fr.shift = frame_fall & ~last_fall; // see R1, R9
   assign fr.stop = early_rise | last_fall;
   assign fr.sample = core_result; // see R7

   asfp_shifter u_shifter (
      .sys_clk(sys_clk),
      .reset(reset),
      .fr(fr)
   );

   // falling-edge counter, restarted at each select fall
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         in_frame_q <= 1'b0;
         edge_cnt_q <= 5'h00;
      end else if (sel_fall) begin
         in_frame_q <= 1'b1; // see R25
         edge_cnt_q <= 5'h00;
      end else if (sel_rise) begin
         in_frame_q <= 1'b0;
      end else if (frame_fall) begin
         edge_cnt_q <= edge_cnt_q + 5'h01; // see R1
      end
   end

   // data pin drive: on at select fall, off at edge sixteen or on an abort
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         oe_q <= 1'b0;
      end else if (sel_fall) begin
         oe_q <= 1'b1; // see R2, R8
      end else if (early_rise) begin
         oe_q <= 1'b0; // see R5, R14, R18
      end else if (last_fall) begin
         oe_q <= 1'b0; // see R4, R9
      end
   end
   // the sixteenth fall arrives while the count still reads fifteen, so it ends the drive
   // rise to release is three sys_clk cycles (24 ns), inside the 35 ns limit

   // sampler hold and return to track
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         hold_q <= 1'b0;
         track_pend_q <= 1'b0;
         wake_track_q <= 1'b0;
      end else if (sel_fall) begin
         hold_q <= 1'b1; // see R2
         track_pend_q <= 1'b0;
         wake_track_q <= pw_down;
      end else if (wake_track_q & (sclk_fall | sclk_rise)) begin
         hold_q <= 1'b0; // see R24
         wake_track_q <= 1'b0;
      end else if (frame_fall & (edge_cnt_q == asfp_pkg::track_after_edge - 5'h01)) begin
         track_pend_q <= 1'b1;
      end else if (track_pend_q & sclk_rise) begin
         hold_q <= 1'b0; // see R3
         track_pend_q <= 1'b0;
      end else if (early_rise) begin
         hold_q <= 1'b0;
         track_pend_q <= 1'b0;
      end
   end

   // power mode decision at select rise from the count reached; select fall from power-down starts a wake, the sixteenth fall completes it
   always_comb begin
      pw_d = pw_q;
      if (sel_fall & pw_down) begin
         pw_d = asfp_pkg::asfp_pw_waking; // see R19
      end else if (early_rise & ~below_ten) begin
         pw_d = asfp_pkg::asfp_pw_normal; // see R14, R19
      end else if (early_rise & (pw_q == asfp_pkg::asfp_pw_waking)) begin
         pw_d = asfp_pkg::asfp_pw_down; // see R20
      end else if (early_rise & ~below_two) begin
         pw_d = asfp_pkg::asfp_pw_down; // see R16
      end else if (last_fall & (pw_q == asfp_pkg::asfp_pw_waking)) begin
         pw_d = asfp_pkg::asfp_pw_normal;
      end
      // rise before edge two leaves normal mode untouched, see R17
   end

   // mode state; the power-on mode is not defined, normal is the reset pick
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pw_q <= asfp_pkg::asfp_pw_normal; // see R23
      end else begin
         pw_q <= pw_d;
      end
   end

   // settle counter: full power only once 1 us has passed since wake began
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pu_cnt_q <= 8'h00;
         strap_done_q <= 1'b0;
      end else if (pw_down) begin
         pu_cnt_q <= 8'h00;
         strap_done_q <= 1'b0;
      end else if (pu_cnt_q != 8'(asfp_pkg::powerup_cycles)) begin
         pu_cnt_q <= pu_cnt_q + 8'h01; // see R21
      end else begin
         strap_done_q <= 1'b1;
      end
   end

   // dummy frame marking: a frame started from power-down carries no valid data
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         dummy_q <= 1'b1;
         valid_q <= 1'b0;
      end else if (sel_fall) begin
         dummy_q <= pw_down | ~strap_done_q; // see R21
         valid_q <= 1'b0;
      end else if (last_fall) begin
         valid_q <= ~dummy_q;
      end else if (abort_rise) begin
         valid_q <= 1'b0; // see R5
      end
   end

   // outputs; data bit is registered in the shifter
   assign result_out = fr.bit_out & oe_q;
   assign result_out_oe = oe_q;
   assign sampler_hold = hold_q;
   assign analog_on = ~pw_down; // see R16
   assign power_good = strap_done_q;
   assign data_valid = valid_q;
endmodule

// File: asfp_ctrl_props.sv
// port checker for the serial frame and power-control block
module asfp_ctrl_props (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // host pins
   input wire logic frame_sel_n,
   input wire logic serial_clk,
   // data pin
   input wire logic result_out,
   input wire logic result_out_oe,
   // converter core
   input wire logic [11:0] core_result,
   input wire logic sampler_hold,
   input wire logic analog_on,
   input wire logic power_good,
   input wire logic data_valid
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // cycles powered so far; saturates so a long run cannot wrap it
   logic [7:0] up_q;
   logic [7:0] up_d;
   assign up_d = !analog_on ? 8'h00 : (up_q == 8'hff ? up_q : up_q + 8'h01);
   always_ff @(posedge sys_clk) begin
      up_q <= reset ? 8'h00 : up_d;
   end
   // frame edges at the select pin
   sequence s_open; $fell(frame_sel_n); endsequence
   sequence s_close; $rose(frame_sel_n); endsequence
   property p_oe_open; s_open |-> ##[3:5] result_out_oe; endproperty
   property p_oe_abort; s_close |-> ##[1:5] !result_out_oe; endproperty
   property p_hold; s_open ##0 analog_on |-> ##[3:5] sampler_hold; endproperty
   property p_lead; $rose(result_out_oe) |-> !result_out; endproperty
   property p_idle; frame_sel_n [*6] |-> !result_out_oe; endproperty
   property p_dv; s_open |-> ##[3:5] !data_valid; endproperty
   property p_pg_off; !analog_on |=> !power_good; endproperty
   property p_pg_time; $rose(power_good) |-> up_q >= 8'h76; endproperty
   property p_down_stay; !analog_on && frame_sel_n |=> !analog_on; endproperty
   a_oe_open: assert property (p_oe_open) else $error("data pin not driven");
   a_oe_abort: assert property (p_oe_abort) else $error("data pin late to float");
   a_hold: assert property (p_hold) else $error("sampler not in hold");
   a_lead: assert property (p_lead) else $error("first bit not zero");
   a_idle: assert property (p_idle) else $error("data pin driven outside frame");
   a_dv: assert property (p_dv) else $error("valid flag kept at new frame");
   a_pg_off: assert property (p_pg_off) else $error("power good while down");
   a_pg_time: assert property (p_pg_time) else $error("power good too early");
   a_down_stay: assert property (p_down_stay) else $error("woke without frame");
endmodule

bind asfp_ctrl asfp_ctrl_props asfp_ctrl_props_inst (.sys_clk, .reset, .frame_sel_n,
   .serial_clk, .result_out, .result_out_oe, .core_result, .sampler_hold, .analog_on,
   .power_good, .data_valid);

// File: asfp_host_model.sv
// host serial port model: frame select, serial clock and bit capture
module asfp_host_model (
   // clock
   input wire logic sys_clk,
   // host pins
   output logic frame_sel_n,
   output logic serial_clk,
   // data pin
   input wire logic result_out,
   input wire logic result_out_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle select high, serial clock parked high between frames
   initial begin
      frame_sel_n = 1'b1;
      serial_clk = 1'b1;
   end
   // n falling edges; each bit is taken just before the fall, x when floated
   task automatic frame(input int n, output logic [15:0] w);
      w = 16'h0000;
      @(posedge sys_clk);
      #1 frame_sel_n = 1'b0;
      #62.5;
      for (int i = 0; i < n; i++) begin
         w = {w[14:0], result_out_oe ? result_out : 1'bx};
         serial_clk = 1'b0;
         #62.5 serial_clk = 1'b1;
         #62.5;
      end
      frame_sel_n = 1'b1;
      #400;
   endtask
endmodule

// File: asfp_ctrl_tb.sv
// self-checking bench for the serial frame and power-control block
module asfp_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk, reset, frame_sel_n, serial_clk, result_out, result_out_oe;
   logic sampler_hold, analog_on, power_good, data_valid;
   logic [11:0] core_result, r;
   logic [15:0] w;
   int mismatches, n_tests;
   int nl[5] = '{1, 5, 8, 10, 12};
   logic el[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
   asfp_ctrl asfp_ctrl_inst (.sys_clk, .reset, .frame_sel_n, .serial_clk, .result_out,
      .result_out_oe, .core_result, .sampler_hold, .analog_on, .power_good, .data_valid);
   asfp_host_model asfp_host_model_inst (.sys_clk, .frame_sel_n, .serial_clk,
      .result_out, .result_out_oe);
   always #4 sys_clk = ~sys_clk;
   // four zeros then the two's complement code
   function automatic logic [15:0] expect_word(input logic [11:0] v);
      return {4'h0, v};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task stop_test;
      if (mismatches == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // one frame; the core word is changed mid-frame to prove it was frozen
   task automatic run(input int n, input logic [11:0] v);
      @(posedge sys_clk);
      #1 core_result = v;
      r = v;
      fork
         asfp_host_model_inst.frame(n, w);
         begin
            repeat (40) @(posedge sys_clk);
            #1 core_result = ~v;
         end
      join
   endtask
   initial begin
      #150us;
      mismatches++;
      stop_test;
   end
   initial begin
      sys_clk = 1'b0;
      reset = 1'b1;
      core_result = 12'h000;
      void'($urandom(32'h83894bcd));
      repeat (3) @(posedge sys_clk);
      #1 reset = 1'b0;
      chk({11'h000, result_out_oe, sampler_hold, analog_on, power_good, data_valid},
         16'h0004);
      repeat (4) @(posedge sys_clk);
      run(16, 12'h5a5);
      chk(16'(data_valid), 16'h0000);
      repeat (130) @(posedge sys_clk);
      chk(16'(power_good), 16'h0001);
      // back-to-back full frames: sign boundaries, then random codes
      for (int k = 0; k < 6; k++) begin
         run(16, k == 0 ? 12'h800 : (k == 1 ? 12'h7ff : 12'($urandom)));
         chk(w, expect_word(r));
         chk({14'h0000, data_valid, result_out_oe}, 16'h0002);
      end
      // glitch, power-down, rejected wake burst, wake, late abort
      for (int k = 0; k < 5; k++) begin
         run(nl[k], 12'($urandom));
         chk({14'h0000, analog_on, result_out_oe}, {14'h0000, el[k], 1'b0});
         chk(16'(data_valid), 16'h0000);
      end
      repeat (130) @(posedge sys_clk);
      run(16, 12'($urandom));
      chk(w, expect_word(r));
      chk({15'h0000, data_valid}, 16'h0001);
      stop_test;
   end
endmodule
